// file: rtl/cond_if.sv
// Bus condition events passed from the 2-wire monitor to the core
`timescale 1ns/10ps
interface cond_if;
	logic start_det;
	logic stop_det;
	logic wr_seq_end;
	modport drv (output start_det, output stop_det, output wr_seq_end);
	modport mon (input start_det, input stop_det, input wr_seq_end);
endinterface

// file: rtl/sup_pkg.sv
// Constants for the supervisor timing and selection logic
package sup_pkg;
	// Clock rate
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned CLK_KHZ = 20_000;
	localparam real         CLK_HZ  = 20.0e6;

	// Power-on reset hold per selection, in ms
	localparam int unsigned POR_DELAY0_MS = 50;
	localparam int unsigned POR_DELAY1_MS = 200;
	localparam int unsigned POR_DELAY2_MS = 400;
	localparam int unsigned POR_DELAY3_MS = 800;
	localparam int unsigned POR0_CYC = POR_DELAY0_MS * CLK_KHZ;
	localparam int unsigned POR1_CYC = POR_DELAY1_MS * CLK_KHZ;
	localparam int unsigned POR2_CYC = POR_DELAY2_MS * CLK_KHZ;
	localparam int unsigned POR3_CYC = POR_DELAY3_MS * CLK_KHZ;

	// Watchdog period per selection
	localparam real         WDOG_PERIOD0_S  = 1.4;
	localparam int unsigned WDOG_PERIOD1_MS = 200;
	localparam int unsigned WDOG_PERIOD2_MS = 25;
	localparam int unsigned WD0_CYC = int'(WDOG_PERIOD0_S * CLK_HZ);
	localparam int unsigned WD1_CYC = WDOG_PERIOD1_MS * CLK_KHZ;
	localparam int unsigned WD2_CYC = WDOG_PERIOD2_MS * CLK_KHZ;

	// Reset hold after a watchdog timeout
	localparam int unsigned WDOG_RST1_MS = 200;
	localparam int unsigned WDOG_RST2_MS = 25;
	localparam int unsigned RST1_CYC = WDOG_RST1_MS * CLK_KHZ;
	localparam int unsigned RST2_CYC = WDOG_RST2_MS * CLK_KHZ;

	// Nonvolatile write cycle, typical and longest
	localparam int unsigned NV_WRITE_CYCLE_TIME_MS = 5;
	localparam int unsigned NV_WRITE_CYCLE_MAX_MS  = 10;
	localparam int unsigned NV_CYC = NV_WRITE_CYCLE_TIME_MS * CLK_KHZ;

	// Short delays; manual reset and glitch times rounded up, warning lead rounded down
	localparam int unsigned LOW_SUPPLY_WARNING_LEAD_NS = 500;
	localparam int unsigned MR_DELAY_NS     = 500;
	localparam int unsigned GLITCH_NS       = 50;
	localparam int unsigned LEAD_CYC = (LOW_SUPPLY_WARNING_LEAD_NS * CLK_MHZ) / 1000;
	localparam int unsigned MR_CYC = (MR_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;

	// Selection codes and reset values
	localparam logic [1:0] POR_SEL_RST = 2'h1;
	localparam logic [1:0] WD_SEL_RST  = 2'h3;
	localparam logic [1:0] WD_SEL_OFF  = 2'h3;
	localparam logic [1:0] WD_SEL_SHORT = 2'h2;
	localparam logic [3:0] IRQ_EN_RST  = 4'h0;

	// Register byte addresses
	localparam logic [11:0] ADDR_CFG      = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_CLR  = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_EN   = 12'h010;

	// Field positions
	localparam int CFG_POR_LSB = 0;
	localparam int CFG_WD_LSB  = 2;
	localparam int ST_POR_LSB  = 0;
	localparam int ST_WD_LSB   = 2;
	localparam int ST_NV_BUSY  = 4;
	localparam int ST_RESET    = 5;
	localparam int ST_LOW_SUPPLY_WARNING  = 6;
	localparam int ST_WDOG     = 7;
	localparam int IRQ_WDOG    = 0;
	localparam int IRQ_NV      = 1;
	localparam int IRQ_PFAIL   = 2;
	localparam int IRQ_MRST    = 3;
endpackage

// file: rtl/supervisor_wdog.sv
// Supervisor timing core: power-on, power-fail, manual and watchdog reset
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
// How it works
// - Two stored bits pick power-on reset hold: 50, 200, 400 or 800 ms.
// - Two stored bits pick watchdog period 1.4 s, 200 ms, 25 ms or off.
// - Watchdog timeout holds reset 200 ms, or 25 ms with short period.
// - Stop ending a write starts a self-timed write cycle within 10 ms.
// - Low-supply warning rises about 500 ns before reset on power-down.
// - Manual reset asserts reset no sooner than 500 ns after activation.
// - Bus input pulses shorter than 50 ns are ignored.
module supervisor_wdog #(
	parameter int unsigned POR0_CYC = sup_pkg::POR0_CYC, // 50 ms hold
	parameter int unsigned POR1_CYC = sup_pkg::POR1_CYC, // 200 ms hold
	parameter int unsigned POR2_CYC = sup_pkg::POR2_CYC, // 400 ms hold
	parameter int unsigned POR3_CYC = sup_pkg::POR3_CYC, // 800 ms hold
	parameter int unsigned WD0_CYC  = sup_pkg::WD0_CYC,  // 1.4 s period
	parameter int unsigned WD1_CYC  = sup_pkg::WD1_CYC,  // 200 ms period
	parameter int unsigned WD2_CYC  = sup_pkg::WD2_CYC,  // 25 ms period
	parameter int unsigned RST1_CYC = sup_pkg::RST1_CYC, // Long timeout hold
	parameter int unsigned RST2_CYC = sup_pkg::RST2_CYC, // Short timeout hold
	parameter int unsigned NV_CYC   = sup_pkg::NV_CYC    // Write cycle
) (
	input  wire logic        core_clk,           // 20 MHz clock
	input  wire logic        nrst,               // Sync reset, active low
	input  wire logic        psel,               // APB select
	input  wire logic        penable,            // APB enable
	input  wire logic        pwrite,             // APB direction
	input  wire logic [11:0] paddr,              // APB byte address
	input  wire logic [31:0] pwdata,             // APB write data
	output logic      [31:0] prdata,             // APB read data
	output logic             pready,             // APB ready
	output logic             pslverr,            // APB error
	input  wire logic        scl_in,             // 2-wire clock line
	input  wire logic        sda_in,             // 2-wire data line
	input  wire logic        vtrip_low_in,       // Supply below trip
	input  wire logic        manual_reset_in,    // Manual reset, high
	output logic             sys_reset_out,      // System reset, high
	output logic             low_supply_warning, // Early power-fail flag
	output logic             wdog_timeout_out,   // Watchdog fired
	output logic             nv_busy_out,        // Write cycle running
	output logic             irq                 // Interrupt level
);
	typedef struct packed {
		logic [1:0]  por_sel;
		logic [1:0]  wd_sel;
		logic [1:0]  por_pend;
		logic [1:0]  wd_pend;
		logic        nv_busy;
		logic [31:0] nv_cnt;
		logic [31:0] wd_cnt;
		logic        wd_fire;
		logic [31:0] rst_cnt;
		logic [31:0] por_cnt;
		logic [7:0]  lr_cnt;
		logic        pf_rst;
		logic        low_warn;
		logic [7:0]  mr_cnt;
		logic        mr_rst;
		logic        rst_out;
		logic [3:0]  irq_st;
		logic [3:0]  irq_en;
		logic        irq;
		logic [31:0] prdata;
		logic        pslverr;
	} st_s;

	localparam logic [7:0] LEAD = 8'(sup_pkg::LEAD_CYC);
	localparam logic [7:0] MRD  = 8'(sup_pkg::MR_CYC);

	st_s        s_r;
	st_s        s_nxt;
	logic [3:0] ev;
	logic [3:0] clr;
	logic       hold;
	cond_if     cond ();

	// Refuse counts the counters cannot serve
	if (POR0_CYC == 0 || POR1_CYC == 0 || POR2_CYC == 0 || POR3_CYC == 0
		|| WD0_CYC == 0 || WD1_CYC == 0 || WD2_CYC == 0 || RST1_CYC == 0
		|| RST2_CYC == 0 || NV_CYC == 0) begin : g_chk_zero
		$error("timing counts must be at least one cycle");
	end
	if (sup_pkg::LEAD_CYC > 255 || sup_pkg::MR_CYC > 255) begin : g_chk_w
		$error("short delay does not fit its counter");
	end

	twowire_cond u_cond (
		.core_clk (core_clk),
		.nrst     (nrst),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.ev       (cond.drv)
	);

	// Power-on hold for a selection
	function automatic logic [31:0] por_len(input logic [1:0] sel);
		case (sel)
			2'h0: por_len = 32'(POR0_CYC);
			2'h1: por_len = 32'(POR1_CYC);
			2'h2: por_len = 32'(POR2_CYC);
			default: por_len = 32'(POR3_CYC);
		endcase
	endfunction

	// Watchdog period; the off code still loads a harmless value
	function automatic logic [31:0] wd_len(input logic [1:0] sel);
		case (sel)
			2'h1: wd_len = 32'(WD1_CYC);
			2'h2: wd_len = 32'(WD2_CYC);
			default: wd_len = 32'(WD0_CYC);
		endcase
	endfunction

	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		ev = 4'h0;
		clr = 4'h0;
		// Zero-wait slave: read data prepared in the setup cycle
		if (psel && !penable) begin
			s_nxt.prdata = 32'h0;
			s_nxt.pslverr = 1'b0;
			case (paddr)
				sup_pkg::ADDR_CFG: begin
					s_nxt.prdata[sup_pkg::CFG_POR_LSB +: 2] = s_r.por_pend;
					s_nxt.prdata[sup_pkg::CFG_WD_LSB +: 2] = s_r.wd_pend;
				end
				sup_pkg::ADDR_STATUS: begin
					s_nxt.prdata[sup_pkg::ST_POR_LSB +: 2] = s_r.por_sel;
					s_nxt.prdata[sup_pkg::ST_WD_LSB +: 2] = s_r.wd_sel;
					s_nxt.prdata[sup_pkg::ST_NV_BUSY] = s_r.nv_busy;
					s_nxt.prdata[sup_pkg::ST_RESET] = s_r.rst_out;
					s_nxt.prdata[sup_pkg::ST_LOW_SUPPLY_WARNING] = s_r.low_warn;
					s_nxt.prdata[sup_pkg::ST_WDOG] = s_r.wd_fire;
				end
				sup_pkg::ADDR_IRQ_STAT: s_nxt.prdata[3:0] = s_r.irq_st;
				sup_pkg::ADDR_IRQ_EN: s_nxt.prdata[3:0] = s_r.irq_en;
				sup_pkg::ADDR_IRQ_CLR: s_nxt.prdata = 32'h0;
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pwrite) begin
			case (paddr)
				sup_pkg::ADDR_CFG: begin
					s_nxt.por_pend = pwdata[sup_pkg::CFG_POR_LSB +: 2];
					s_nxt.wd_pend = pwdata[sup_pkg::CFG_WD_LSB +: 2];
				end
				sup_pkg::ADDR_IRQ_CLR: clr = pwdata[3:0];
				sup_pkg::ADDR_IRQ_EN: s_nxt.irq_en = pwdata[3:0];
				default: clr = 4'h0;
			endcase
		end

		// Power-on hold counts down from reset or supply return
		if (s_r.por_cnt != 32'h0) s_nxt.por_cnt = s_r.por_cnt - 32'h1;

		// Warning at once, reset after the lead time
		s_nxt.low_warn = vtrip_low_in;
		if (vtrip_low_in) begin
			if (s_r.lr_cnt == LEAD) s_nxt.pf_rst = 1'b1;
			else s_nxt.lr_cnt = s_r.lr_cnt + 8'h1;
		end else begin
			s_nxt.lr_cnt = 8'h0;
			s_nxt.pf_rst = 1'b0;
			if (s_r.pf_rst) s_nxt.por_cnt = por_len(s_r.por_sel);
		end

		// Delay applies to activation; release is immediate
		if (manual_reset_in) begin
			if (s_r.mr_cnt == MRD) s_nxt.mr_rst = 1'b1;
			else s_nxt.mr_cnt = s_r.mr_cnt + 8'h1;
		end else begin
			s_nxt.mr_cnt = 8'h0;
			s_nxt.mr_rst = 1'b0;
		end

		// Watchdog, held at full period while any other reset stands
		hold = s_r.por_cnt != 32'h0 || s_r.pf_rst || s_r.mr_rst;
		if (s_r.wd_fire) begin
			if (s_r.rst_cnt == 32'h1) begin
				s_nxt.wd_fire = 1'b0;
				s_nxt.wd_cnt = wd_len(s_r.wd_sel);
			end else begin
				s_nxt.rst_cnt = s_r.rst_cnt - 32'h1;
			end
		end else if (s_r.wd_sel == sup_pkg::WD_SEL_OFF || hold
				|| cond.start_det) begin
			s_nxt.wd_cnt = wd_len(s_r.wd_sel);
		end else if (s_r.wd_cnt == 32'h1) begin
			s_nxt.wd_fire = 1'b1;
			s_nxt.rst_cnt = (s_r.wd_sel == sup_pkg::WD_SEL_SHORT) ?
				32'(RST2_CYC) : 32'(RST1_CYC);
			ev[sup_pkg::IRQ_WDOG] = 1'b1;
		end else begin
			s_nxt.wd_cnt = s_r.wd_cnt - 32'h1;
		end

		// Write cycle; stops arriving mid-cycle are not acted on
		if (s_r.nv_busy) begin
			if (s_r.nv_cnt == 32'h1) begin
				s_nxt.nv_busy = 1'b0;
				s_nxt.por_sel = s_r.por_pend;
				s_nxt.wd_sel = s_r.wd_pend;
				ev[sup_pkg::IRQ_NV] = 1'b1;
			end else begin
				s_nxt.nv_cnt = s_r.nv_cnt - 32'h1;
			end
		end else if (cond.wr_seq_end) begin
			s_nxt.nv_busy = 1'b1;
			s_nxt.nv_cnt = 32'(NV_CYC);
		end

		// Sticky events; a new event beats a same-cycle clear
		ev[sup_pkg::IRQ_PFAIL] = s_nxt.pf_rst && !s_r.pf_rst;
		ev[sup_pkg::IRQ_MRST] = s_nxt.mr_rst && !s_r.mr_rst;
		s_nxt.irq_st = (s_r.irq_st & ~clr) | ev;
		s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_en);
		s_nxt.rst_out = s_nxt.por_cnt != 32'h0 || s_nxt.pf_rst
			|| s_nxt.mr_rst || s_nxt.wd_fire;
	end

	// State register with factory selections after reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.por_sel <= sup_pkg::POR_SEL_RST;
			s_r.wd_sel <= sup_pkg::WD_SEL_RST;
			s_r.por_pend <= sup_pkg::POR_SEL_RST;
			s_r.wd_pend <= sup_pkg::WD_SEL_RST;
			s_r.irq_en <= sup_pkg::IRQ_EN_RST;
			s_r.por_cnt <= 32'(POR1_CYC);
			s_r.wd_cnt <= 32'(WD0_CYC);
			s_r.rst_out <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from state, except pready, which is tied high
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign pready = 1'b1;
	assign sys_reset_out = s_r.rst_out;
	assign low_supply_warning = s_r.low_warn;
	assign wdog_timeout_out = s_r.wd_fire;
	assign nv_busy_out = s_r.nv_busy;
	assign irq = s_r.irq;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// Checks tie each timed output to its cause
	a_por_hold: assert property (s_r.por_cnt != 32'h0 |-> sys_reset_out)
		else $error("reset dropped during power-on hold");
	a_wdog_off: assert property (
		s_r.wd_sel == sup_pkg::WD_SEL_OFF && !s_r.wd_fire
		|=> !wdog_timeout_out)
		else $error("disabled watchdog fired");
	a_wdog_rst_len: assert property ($rose(wdog_timeout_out) |->
		s_r.rst_cnt == ((s_r.wd_sel == sup_pkg::WD_SEL_SHORT) ?
		32'(RST2_CYC) : 32'(RST1_CYC)) && sys_reset_out)
		else $error("watchdog reset hold length wrong");
	a_nv_start: assert property (cond.wr_seq_end && !s_r.nv_busy
		|=> nv_busy_out && s_r.nv_cnt == 32'(NV_CYC))
		else $error("write cycle did not start on stop");
	a_nv_commit: assert property (s_r.nv_busy && s_r.nv_cnt == 32'h1
		|=> !nv_busy_out && s_r.wd_sel == $past(s_r.wd_pend)
		&& s_r.por_sel == $past(s_r.por_pend))
		else $error("write cycle end did not commit selections");
	a_low_supply_warning_lead: assert property ($rose(s_r.pf_rst) |->
		$past(low_supply_warning, 10) && low_supply_warning)
		else $error("power-fail reset came before the warning lead");
	a_pf_reset: assert property (vtrip_low_in && s_r.lr_cnt == LEAD
		|=> sys_reset_out && low_supply_warning)
		else $error("power-fail reset missing after warning lead");
	a_warn_on: assert property (vtrip_low_in |=> low_supply_warning)
		else $error("low-supply warning did not follow the trip input");
	a_mr_delay: assert property ($rose(s_r.mr_rst) |->
		$past(manual_reset_in, 10) && $past(manual_reset_in, 5))
		else $error("manual reset asserted too early");
	a_mr_release: assert property (s_r.mr_rst && !manual_reset_in
		|=> !s_r.mr_rst)
		else $error("manual reset not released at once");
	a_wdog_fire: assert property (!s_r.wd_fire && !hold
		&& s_r.wd_sel != sup_pkg::WD_SEL_OFF && !cond.start_det
		&& s_r.wd_cnt == 32'h1 |=> wdog_timeout_out ##1 sys_reset_out)
		else $error("watchdog did not fire at period end");
	a_wdog_restart: assert property (cond.start_det && !s_r.wd_fire
		|=> s_r.wd_cnt == wd_len($past(s_r.wd_sel)))
		else $error("start condition did not reload watchdog");

	c_wdog_fire: cover property ($rose(wdog_timeout_out));
	c_nv_done: cover property ($fell(nv_busy_out));
	c_power_fail: cover property ($rose(s_r.pf_rst));
	c_manual: cover property ($rose(s_r.mr_rst));
	c_restart: cover property (cond.start_det
		&& s_r.wd_sel != sup_pkg::WD_SEL_OFF);
endmodule // supervisor_wdog

// file: rtl/twowire_cond.sv
// Glitch filter and start/stop/write detection on the 2-wire bus
`timescale 1ns/10ps
module twowire_cond (
	input  wire logic core_clk, // System clock
	input  wire logic nrst,     // Synchronous reset, active low
	input  wire logic scl_in,   // Bus clock line
	input  wire logic sda_in,   // Bus data line
	cond_if.drv       ev        // Detected conditions
);
	typedef struct packed {
		logic       scl_p;
		logic       sda_p;
		logic       scl_f;
		logic       sda_f;
		logic       active;
		logic [3:0] bitcnt;
		logic       rw;
		logic       wr_ok;
		logic       start_p;
		logic       stop_p;
		logic       wrend_p;
	} cond_s;

	cond_s s_r;
	cond_s s_nxt;

	if (sup_pkg::GLITCH_CYC != 1) begin : g_chk
		$error("glitch filter built for a one-cycle suppression window");
	end

	// Filter, then edge and condition decode on filtered lines
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_p = scl_in;
		s_nxt.sda_p = sda_in;
		s_nxt.start_p = 1'b0;
		s_nxt.stop_p = 1'b0;
		s_nxt.wrend_p = 1'b0;
		// A level passes only when seen on two samples in a row
		if (scl_in == s_r.scl_p) s_nxt.scl_f = scl_in;
		if (sda_in == s_r.sda_p) s_nxt.sda_f = sda_in;
		if (s_r.scl_f && s_nxt.scl_f && s_r.sda_f && !s_nxt.sda_f) begin
			s_nxt.start_p = 1'b1;
			s_nxt.active = 1'b1;
			s_nxt.bitcnt = 4'h0;
			s_nxt.wr_ok = 1'b0;
		end else if (s_r.scl_f && s_nxt.scl_f && !s_r.sda_f
				&& s_nxt.sda_f) begin
			s_nxt.stop_p = 1'b1;
			s_nxt.wrend_p = s_r.active && s_r.wr_ok;
			s_nxt.active = 1'b0;
		end else if (!s_r.scl_f && s_nxt.scl_f && s_r.active) begin
			// Eighth bit is direction, ninth is the acknowledge slot
			if (s_r.bitcnt == 4'h7) s_nxt.rw = s_nxt.sda_f;
			if (s_r.bitcnt == 4'h8) s_nxt.wr_ok = !s_r.rw;
			if (s_r.bitcnt != 4'h9) s_nxt.bitcnt = s_r.bitcnt + 4'h1;
		end
	end

	// State register; lines idle high after reset
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.scl_p <= 1'b1;
			s_r.sda_p <= 1'b1;
			s_r.scl_f <= 1'b1;
			s_r.sda_f <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ev.start_det = s_r.start_p;
	assign ev.stop_det = s_r.stop_p;
	assign ev.wr_seq_end = s_r.wrend_p;

	a_glitch_scl: assert property (@(posedge core_clk) disable iff (!nrst)
		$changed(s_r.scl_f) |-> $past(scl_in) == s_r.scl_f
		&& $past(scl_in, 2) == s_r.scl_f)
		else $error("scl filter passed a short pulse");
	a_glitch_sda: assert property (@(posedge core_clk) disable iff (!nrst)
		$changed(s_r.sda_f) |-> $past(sda_in) == s_r.sda_f
		&& $past(sda_in, 2) == s_r.sda_f)
		else $error("sda filter passed a short pulse");
endmodule // twowire_cond

// file: tb/host_model.sv
// Host side of the 2-wire bus: restarts, write or read headers, glitches
`timescale 1ns/10ps
module host_model #(
	parameter int H = 4 // Half bit time in clocks
) (
	input  wire logic core_clk, // System clock
	output logic      scl_out,  // Bus clock, pulled high when idle
	output logic      sda_out   // Bus data, pulled high when idle
);
	// Both lines released to the pull-up level
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end

	// Wait a number of clock edges
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Start then stop, low time long enough to count as a restart
	task automatic restart();
		tk(1);
		sda_out <= 1'b0;
		tk(20);
		sda_out <= 1'b1;
		tk(H);
	endtask

	// Start, one header byte, released ack bit, stop
	task automatic seq(input logic [7:0] b);
		tk(1);
		sda_out <= 1'b0;
		tk(20);
		scl_out <= 1'b0;
		tk(H);
		for (int k = 0; k < 9; k++) begin
			sda_out <= (k < 8) ? b[7-k] : 1'b1;
			tk(H);
			scl_out <= 1'b1;
			tk(H);
			scl_out <= 1'b0;
		end
		sda_out <= 1'b0;
		tk(H);
		scl_out <= 1'b1;
		tk(H);
		sda_out <= 1'b1;
		tk(H);
	endtask

	// One-sample dip on data while clock is high
	task automatic glitch();
		tk(1);
		sda_out <= 1'b0;
		tk(1);
		sda_out <= 1'b1;
		tk(H);
	endtask
endmodule // host_model

// file: tb/supervisor_watchdog_reset_timing_bench.sv
// Self-checking bench for the supervisor timing core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module supervisor_watchdog_reset_timing_bench;
	// Shortened counts keep the run brief
	localparam int PC [4] = '{60, 100, 140, 180};
	localparam int WC [3] = '{900, 600, 400};
	localparam int R1 = 100;
	localparam int R2 = 50;
	localparam int NV = 200;

	logic        core_clk, nrst, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, r;
	logic        pready, pslverr, e, scl, sda, vtrip, man_rst;
	logic        sys_rst, low, wdog, nvb, irq;
	logic [1:0]  s;
	logic [4:0]  outs;
	int          failures, n_tests, n, t0;
	int          cyc = 0;

	assign outs = {irq, nvb, wdog, low, sys_rst};

	supervisor_wdog #(
		.POR0_CYC(PC[0]), .POR1_CYC(PC[1]), .POR2_CYC(PC[2]),
		.POR3_CYC(PC[3]), .WD0_CYC(WC[0]), .WD1_CYC(WC[1]),
		.WD2_CYC(WC[2]), .RST1_CYC(R1), .RST2_CYC(R2), .NV_CYC(NV)
	) dut_u (
		.core_clk(core_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .sda_in(sda),
		.vtrip_low_in(vtrip), .manual_reset_in(man_rst),
		.sys_reset_out(sys_rst), .low_supply_warning(low),
		.wdog_timeout_out(wdog), .nv_busy_out(nvb), .irq(irq)
	);

	host_model host_u (.core_clk(core_clk), .scl_out(scl), .sda_out(sda));

	// Expected reset hold after a timeout
	function automatic int hold_c(input int sel);
		return (sel == 2) ? R2 : R1;
	endfunction

	// 20 MHz clock and a free cycle count
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	// One APB transfer; read data and error land in q and e
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int t;
		@(posedge core_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge core_clk);
			t++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		`CHK("apb wait", 1, t)
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Count settled edges until an output bit reaches a level
	task automatic wt(input int b, input logic v, input int lim,
		output int k);
		k = 0;
		while (outs[b] !== v && k < lim) begin
			@(posedge core_clk);
			#1;
			k++;
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard, well beyond the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		report_and_stop();
	end

	initial begin
		nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; vtrip = 1'b0; man_rst = 1'b0;
		failures = 0; n_tests = 0;
		r = $urandom(93);
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		#1;
		wt(0, 1'b0, 400, n);
		`CHK("por default", 1'b1, n >= PC[1] - 3 && n <= PC[1] + 3)
		apb(1'b0, sup_pkg::ADDR_CFG, '0);
		`CHK("cfg reset", 32'h0000000d, q)
		apb(1'b0, sup_pkg::ADDR_STATUS, '0);
		`CHK("active sel", 4'hd, q[3:0])
		apb(1'b0, sup_pkg::ADDR_IRQ_EN, '0);
		`CHK("irq en reset", 32'h0, q)
		apb(1'b0, 12'h020, '0);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, q)

		// Each selection: stage, commit by a write sequence, then time it
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			r = $urandom();
			apb(1'b1, sup_pkg::ADDR_CFG, {r[27:0], s, s});
			apb(1'b0, sup_pkg::ADDR_CFG, '0);
			`CHK("cfg staged", {28'h0, s, s}, q)
			host_u.seq({r[31:25], 1'b1});
			wt(3, 1'b1, 20, n);
			`CHK("read no cycle", 20, n)
			host_u.seq({r[31:25], 1'b0});
			wt(3, 1'b1, 20, n);
			`CHK("busy rise", 1'b1, n < 20)
			wt(3, 1'b0, NV + 20, n); // Host holds off until done
			`CHK("busy len", 1'b1, n >= NV - 2 && n <= NV + 2)
			apb(1'b0, sup_pkg::ADDR_STATUS, '0);
			`CHK("committed", {4'h0, s, s}, q[7:0])
			// Supply dip: warning leads reset, then selected hold
			host_u.restart();
			vtrip <= 1'b1;
			wt(1, 1'b1, 5, n);
			wt(0, 1'b1, 30, n);
			`CHK("warn lead", 1'b1, n >= 10 && n <= 11)
			apb(1'b0, sup_pkg::ADDR_STATUS, '0);
			`CHK("dip status", 2'h3, q[6:5])
			vtrip <= 1'b0;
			wt(1, 1'b0, 5, n);
			wt(0, 1'b0, 400, n);
			`CHK("por sel", 1'b1, n >= PC[i] - 3 && n <= PC[i] + 3)
			if (i < 3) begin
				repeat (3) begin
					host_u.restart();
					repeat (WC[i] - 60) @(posedge core_clk);
					#1;
					`CHK("restarted", 1'b0, wdog)
				end
				t0 = cyc;
				host_u.restart();
				repeat (WC[i] / 2) @(posedge core_clk);
				host_u.glitch();
				wt(2, 1'b1, WC[i], n);
				`CHK("period", 1'b1, cyc - t0 >= WC[i] &&
					cyc - t0 <= WC[i] + 12)
				@(posedge core_clk);
				#1;
				`CHK("wd reset", 1'b1, sys_rst)
				wt(2, 1'b0, 400, n);
				`CHK("hold", 1'b1, n >= hold_c(i) - 3 &&
					n <= hold_c(i) + 2)
			end else begin
				wt(2, 1'b1, 1000, n);
				`CHK("wd off", 1000, n)
			end
		end

		// Manual reset assertion delay
		man_rst <= 1'b1;
		wt(0, 1'b1, 30, n);
		`CHK("mr delay", 1'b1, n >= 10 && n <= 12)
		man_rst <= 1'b0;
		wt(0, 1'b0, 5, n);
		`CHK("mr release", 1'b1, n < 5)

		// Sticky events, mask, clear
		apb(1'b0, sup_pkg::ADDR_IRQ_STAT, '0);
		`CHK("irq stat", 32'hf, q)
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, sup_pkg::ADDR_IRQ_EN, 32'h1);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, sup_pkg::ADDR_IRQ_CLR, 32'h1);
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("irq off", 1'b0, irq)
		apb(1'b0, sup_pkg::ADDR_IRQ_STAT, '0);
		`CHK("stat left", 32'he, q)
		apb(1'b0, sup_pkg::ADDR_IRQ_CLR, '0);
		`CHK("clr reads 0", 32'h0, q)
		apb(1'b1, 12'h020, 32'hf);
		`CHK("unmapped wr", 1'b1, e)
		apb(1'b1, sup_pkg::ADDR_IRQ_CLR, 32'hf);
		apb(1'b0, sup_pkg::ADDR_IRQ_STAT, '0);
		`CHK("stat clear", 32'h0, q)
		report_and_stop();
	end
endmodule // supervisor_watchdog_reset_timing_bench
